// ==== design/usc_pkg.sv ====
package usc_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_TXDATA   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_CFG      = 8'h10;

  // ****************************************************************
  // serial_status_control_reg fields
  // ****************************************************************
  localparam int B_TXSEL_HI = 15;
  localparam int B_TXINV    = 14;
  localparam int B_TXSEL_LO = 13;
  localparam int B_UNIMP    = 12;
  localparam int B_BRK      = 11;
  localparam int B_TXEN     = 10;
  localparam int B_TXBF     = 9;
  localparam int B_TX_SHIFT_EMPTY     = 8;
  localparam int B_RXSEL_HI = 7;
  localparam int B_RXSEL_LO = 6;
  localparam int B_ADDRESS_DETECT_ENABLE    = 5;
  localparam int B_RECEIVER_IDLE    = 4;
  localparam int B_PARITY_ERROR_FLAG     = 3;
  localparam int B_FRAMING_ERROR_FLAG     = 2;
  localparam int B_OVERRUN_ERROR_FLAG     = 1;
  localparam int B_RXDA     = 0;

  localparam logic [1:0] TXSEL_EACH  = 2'h0;
  localparam logic [1:0] TXSEL_DONE  = 2'h1;
  localparam logic [1:0] TXSEL_EMPTY = 2'h2;
  localparam logic [1:0] RXSEL_FULL  = 2'h3;
  localparam logic [1:0] RXSEL_3Q    = 2'h2;

  localparam logic [2:0] RX_FULL_LEVEL = 3'h4;
  localparam logic [2:0] RX_3Q_LEVEL   = 3'h3;

  // ****************************************************************
  // interrupt status / mask and config fields
  // ****************************************************************
  localparam int IRQ_TX  = 0;
  localparam int IRQ_RX  = 1;
  localparam int IRQ_BRK = 2;
  localparam int IRQ_W   = 3;
  localparam int CFG_INFRARED_ENCODE_ENABLE = 0;

  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
  localparam logic             RECEIVER_IDLE_RESET    = 1'b1;

  // ****************************************************************
  // framing and timing
  // ****************************************************************
  localparam int TX_DEPTH    = 4;
  localparam int DATA_BITS   = 8;
  localparam int BREAK_ZEROS = 12;
  localparam int CLK_PERIOD_NS = 100;
  localparam int BIT_TIME_NS   = 1600;
  localparam int IR_PULSE_NS   = 300;
  localparam int BIT_CYCLES    = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int IR_PULSE_CYCLES = (IR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ==== design/usc_tx_mem.sv ====
`timescale 1ns/1ns
module usc_tx_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rdata_q;

  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
    end else if (ce_i) begin
      rdata_q <= mem_q[raddr_i];
    end
  end

  assign rdata_o = rdata_q;

endmodule

// ==== design/usc_top.sv ====
`timescale 1ns/1ns
// Behaviour
// R01: select 00: interrupt on each shift load
// R02: select 01: interrupt when all transmission done
// R03: select 10: interrupt when load empties buffer
// R04: software never programs select 11
// R05: no infrared: invert set idles line low
// R06: infrared: invert set encodes idle one
// R07: break: start, twelve zeros, stop
// R08: hardware clears break bit after break
// R09: transmit enable drives the transmit pin
// R10: disable aborts, flushes buffer, releases pin
// R11: buffer full flag reads buffer full
// R12: shift empty flag: nothing queued, reset one
// R13: receive select 11: interrupt at four characters
// R14: receive select 10: interrupt at three characters
// R15: receive select 0x: interrupt every character
// R16: bit 12 always reads zero
// R17: overrun sticky, software clears; others read-only
module usc_top
  import usc_pkg::*;
#(
  parameter int BIT_CYCLES_P = BIT_CYCLES,
  parameter int IR_CYCLES_P  = IR_PULSE_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic             serial_tx_pin_o,
  output logic             serial_tx_pin_oe_o,
  output logic             address_detect_enable_o,
  input  wire logic        rx_push_i,
  input  wire logic [2:0]  rx_level_i,
  input  wire logic        receiver_idle_i,
  input  wire logic        parity_error_i,
  input  wire logic        framing_error_i,
  input  wire logic        rx_overrun_i,
  input  wire logic        rx_data_available_i,
  output logic             irq_o
);

  typedef enum logic [2:0] {TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_STOP} usc_tx_state_e;

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  logic        wr_q;
  logic        rd_wait_q;
  logic [7:0]  waddr_q;
  logic [7:0]  raddr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;

  wire addr_ok  = (haddr_i[31:8] == 24'h000000) && (haddr_i[1:0] == 2'h0);
  wire accept   = hsel_i && htrans_i[1] && hready_i;
  wire wr_ctrl  = wr_q && (waddr_q == ADDR_CTRL);
  wire wr_txd   = wr_q && (waddr_q == ADDR_TXDATA);
  wire wr_stat  = wr_q && (waddr_q == ADDR_IRQ_STAT);
  wire wr_mask  = wr_q && (waddr_q == ADDR_IRQ_MASK);
  wire wr_cfg   = wr_q && (waddr_q == ADDR_CFG);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q      <= 1'b0;
      rd_wait_q <= 1'b0;
      waddr_q   <= 8'h00;
      raddr_q   <= 8'h00;
      hrdata_q  <= 32'h00000000;
    end else if (ce_i) begin
      wr_q      <= accept && hwrite_i && addr_ok;
      rd_wait_q <= accept && !hwrite_i;
      waddr_q   <= haddr_i[7:0];
      if (accept) begin
        raddr_q <= addr_ok ? haddr_i[7:0] : 8'hff;
      end
      if (rd_wait_q) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  assign hreadyout_o = !rd_wait_q;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_q;

  // ****************************************************************
  // control and status state
  // ****************************************************************
  logic [1:0]       txsel_q;
  logic             inv_q;
  logic             brk_q;
  logic             txen_q;
  logic [1:0]       rxsel_q;
  logic             address_detect_enable_q;
  logic             infrared_encode_enable_q;
  logic             receiver_idle_q;
  logic             parity_error_flag_q;
  logic             framing_error_flag_q;
  logic             overrun_error_flag_q;
  logic             rxda_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_ev;
  logic             brk_done;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txsel_q <= TXSEL_EACH;
      inv_q   <= 1'b0;
      txen_q  <= 1'b0;
      rxsel_q <= 2'h0;
      address_detect_enable_q <= 1'b0;
      infrared_encode_enable_q  <= 1'b0;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        txsel_q <= {hwdata_i[B_TXSEL_HI], hwdata_i[B_TXSEL_LO]}; // R01
        inv_q   <= hwdata_i[B_TXINV];
        txen_q  <= hwdata_i[B_TXEN];
        rxsel_q <= hwdata_i[B_RXSEL_HI:B_RXSEL_LO];
        address_detect_enable_q <= hwdata_i[B_ADDRESS_DETECT_ENABLE];
      end
      if (wr_cfg) begin
        infrared_encode_enable_q <= hwdata_i[CFG_INFRARED_ENCODE_ENABLE];
      end
    end
  end

  // break bit: a software write beats the hardware clear
  wire brk_d = wr_ctrl ? hwdata_i[B_BRK] : (brk_done ? 1'b0 : brk_q); // R08
  // overrun: hardware set beats software clear by writing zero
  wire overrun_error_flag_d = rx_overrun_i || (overrun_error_flag_q && !(wr_ctrl && !hwdata_i[B_OVERRUN_ERROR_FLAG])); // R17
  wire [IRQ_W-1:0] stat_d = irq_ev | (irq_stat_q & ~(wr_stat ? hwdata_i[IRQ_W-1:0] : '0));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      brk_q      <= 1'b0;
      overrun_error_flag_q     <= 1'b0;
      receiver_idle_q    <= RECEIVER_IDLE_RESET;
      parity_error_flag_q     <= 1'b0;
      framing_error_flag_q     <= 1'b0;
      rxda_q     <= 1'b0;
      irq_stat_q <= '0;
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (ce_i) begin
      brk_q      <= brk_d;
      overrun_error_flag_q     <= overrun_error_flag_d;
      receiver_idle_q    <= receiver_idle_i; // R17
      parity_error_flag_q     <= parity_error_i;
      framing_error_flag_q     <= framing_error_i;
      rxda_q     <= rx_data_available_i;
      irq_stat_q <= stat_d;
      if (wr_mask) begin
        irq_mask_q <= hwdata_i[IRQ_W-1:0];
      end
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);
  assign address_detect_enable_o = address_detect_enable_q;

  // ****************************************************************
  // transmit buffer
  // ****************************************************************
  logic [1:0] wptr_q;
  logic [1:0] rptr_q;
  logic [2:0] cnt_q;
  logic [7:0] buf_rdata;
  logic       pop;

  wire buf_full = (cnt_q == 3'(TX_DEPTH));
  wire push     = wr_txd && txen_q && !buf_full;
  wire txen_d   = wr_ctrl ? hwdata_i[B_TXEN] : txen_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr_q <= 2'h0;
      rptr_q <= 2'h0;
      cnt_q  <= 3'h0;
    end else if (ce_i) begin
      if (!txen_d) begin
        wptr_q <= 2'h0; // R10
        rptr_q <= 2'h0;
        cnt_q  <= 3'h0;
      end else begin
        wptr_q <= wptr_q + 2'(push);
        rptr_q <= rptr_q + 2'(pop);
        cnt_q  <= cnt_q + 3'(push) - 3'(pop);
      end
    end
  end

  usc_tx_mem #(.WIDTH(DATA_BITS), .DEPTH(TX_DEPTH), .AW(2)) u_mem (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .we_i    (push),
    .waddr_i (wptr_q),
    .wdata_i (hwdata_i[7:0]),
    .raddr_i (rptr_q),
    .rdata_o (buf_rdata)
  );

  // ****************************************************************
  // transmit shifter
  // ****************************************************************
  usc_tx_state_e st_q;
  usc_tx_state_e st_d;
  logic [11:0]   sh_q;
  logic [11:0]   sh_d;
  logic [3:0]    nb_q;
  logic [3:0]    nb_d;
  logic          bf_q;
  logic          bf_d;
  logic [7:0]    bc_q;
  logic          frame_done;
  logic          raw;
  logic          line_q;

  wire bit_end = (bc_q == 8'(BIT_CYCLES_P - 1));
  wire timing  = (st_q == TX_START) || (st_q == TX_DATA) || (st_q == TX_STOP);

  always_comb begin
    st_d       = st_q;
    sh_d       = sh_q;
    nb_d       = nb_q;
    bf_d       = bf_q;
    pop        = 1'b0;
    frame_done = 1'b0;
    raw        = 1'b1;
    case (st_q)
      TX_IDLE: begin
        if (txen_q && brk_q) begin
          st_d = TX_START; // R07
          sh_d = 12'h000;
          nb_d = 4'(BREAK_ZEROS);
          bf_d = 1'b1;
        end else if (txen_q && (cnt_q != 3'h0)) begin
          pop  = 1'b1;
          st_d = TX_LOAD;
        end
      end
      TX_LOAD: begin
        sh_d = {4'h0, buf_rdata};
        nb_d = 4'(DATA_BITS);
        bf_d = 1'b0;
        st_d = TX_START;
      end
      TX_START: begin
        raw = 1'b0;
        if (bit_end) begin
          st_d = TX_DATA;
        end
      end
      TX_DATA: begin
        raw = sh_q[0];
        if (bit_end) begin
          sh_d = {1'b0, sh_q[11:1]};
          nb_d = nb_q - 4'h1;
          if (nb_q == 4'h1) begin
            st_d = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (bit_end) begin
          frame_done = 1'b1;
          st_d       = TX_IDLE;
        end
      end
      default: begin
        st_d = TX_IDLE;
      end
    endcase
  end

  assign brk_done = frame_done && bf_q; // R08

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= TX_IDLE;
      sh_q <= 12'h000;
      nb_q <= 4'h0;
      bf_q <= 1'b0;
      bc_q <= 8'h00;
    end else if (ce_i) begin
      st_q <= txen_d ? st_d : TX_IDLE; // R10
      sh_q <= sh_d;
      nb_q <= nb_d;
      bf_q <= bf_d;
      bc_q <= (!timing || bit_end || !txen_d) ? 8'h00 : bc_q + 8'h01;
    end
  end

  // ****************************************************************
  // line encoding and pin
  // ****************************************************************
  wire ir_pulse = !raw && (bc_q < 8'(IR_CYCLES_P));
  wire line_ir  = ir_pulse ? !inv_q : inv_q; // R06
  wire line_d   = infrared_encode_enable_q ? line_ir : (raw ^ inv_q); // R05

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_q <= 1'b1;
    end else if (ce_i) begin
      line_q <= line_d;
    end
  end

  assign serial_tx_pin_o    = line_q;
  assign serial_tx_pin_oe_o = txen_q; // R09

  // ****************************************************************
  // interrupt events
  // ****************************************************************
  wire tx_ev_each  = pop; // R01
  wire tx_ev_empty = pop && (cnt_q == 3'h1) && !push; // R03
  wire tx_ev_done  = frame_done && (cnt_q == 3'h0) && !push; // R02
  wire rx_ev_full  = rx_push_i && (rx_level_i == RX_FULL_LEVEL); // R13
  wire rx_ev_3q    = rx_push_i && (rx_level_i == RX_3Q_LEVEL); // R14

  assign irq_ev[IRQ_TX] = (txsel_q == TXSEL_EACH)  ? tx_ev_each  :
                          (txsel_q == TXSEL_DONE)  ? tx_ev_done  :
                          (txsel_q == TXSEL_EMPTY) ? tx_ev_empty : 1'b0; // R04
  assign irq_ev[IRQ_RX] = (rxsel_q == RXSEL_FULL) ? rx_ev_full :
                          (rxsel_q == RXSEL_3Q)   ? rx_ev_3q   : rx_push_i; // R15
  assign irq_ev[IRQ_BRK] = brk_done;

  // ****************************************************************
  // read mux
  // ****************************************************************
  wire tx_shift_empty = (st_q == TX_IDLE) && (cnt_q == 3'h0) && !brk_q; // R12
  wire [15:0] ctrl_rd = {txsel_q[1], inv_q, txsel_q[0], 1'b0, brk_q, txen_q, buf_full, // R16
                         tx_shift_empty, rxsel_q, address_detect_enable_q, receiver_idle_q, parity_error_flag_q, framing_error_flag_q, // R11
                         overrun_error_flag_q, rxda_q};

  assign rd_mux = (raddr_q == ADDR_CTRL)     ? {16'h0000, ctrl_rd} :
                  (raddr_q == ADDR_IRQ_STAT) ? {29'h0, irq_stat_q} :
                  (raddr_q == ADDR_IRQ_MASK) ? {29'h0, irq_mask_q} :
                  (raddr_q == ADDR_CFG)      ? {31'h0, infrared_encode_enable_q}     : 32'h00000000;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_TX_EACH: assert property ((ce_i && pop && txsel_q == TXSEL_EACH) |=> irq_stat_q[IRQ_TX]) // R01
    else $error("tx load did not flag interrupt");
  AST_TX_DONE: assert property ((ce_i && tx_ev_done && txsel_q == TXSEL_DONE) |=> // R02
                                (irq_stat_q[IRQ_TX] && st_q == TX_IDLE))
    else $error("tx completion not flagged");
  AST_TX_EMPTY: assert property ((ce_i && pop && cnt_q == 3'h2 && txsel_q == TXSEL_EMPTY && // R03
                                  !wr_stat) |=> $stable(irq_stat_q[IRQ_TX]))
    else $error("empty mode flagged with data left");
  AST_IDLE_PLAIN: assert property ((st_q == TX_IDLE && !infrared_encode_enable_q && $stable(inv_q) && ce_i)[*2] // R05
                                   |-> serial_tx_pin_o == !inv_q)
    else $error("plain idle level wrong");
  AST_IDLE_IR: assert property ((st_q == TX_IDLE && infrared_encode_enable_q && $stable(inv_q) && ce_i)[*2] // R06
                                |-> serial_tx_pin_o == inv_q)
    else $error("encoded idle level wrong");
  AST_BRK_ZERO: assert property ((bf_q && st_q == TX_DATA) |-> raw == 1'b0 && nb_q <= 4'hc) // R07
    else $error("break frame carries a one");
  AST_BRK_CLR: assert property ((ce_i && brk_done && !wr_ctrl) |=> !brk_q && irq_stat_q[IRQ_BRK]) // R08
    else $error("break bit not cleared");
  AST_TXEN_PIN: assert property ((ce_i && wr_ctrl && hwdata_i[B_TXEN]) |=> serial_tx_pin_oe_o) // R09
    else $error("pin not taken on enable");
  AST_ABORT: assert property ($fell(txen_q) |-> (st_q == TX_IDLE && cnt_q == 3'h0 && // R10
                                                 !serial_tx_pin_oe_o))
    else $error("disable did not abort");
  AST_FULL: assert property (ctrl_rd[B_TXBF] == (cnt_q == 3'h4)) // R11
    else $error("full flag mismatch");
  AST_TX_SHIFT_EMPTY: assert property ((ce_i && push) |=> !ctrl_rd[B_TX_SHIFT_EMPTY]) // R12
    else $error("shift empty high with data queued");
  AST_RX_FULL: assert property ((ce_i && rx_push_i && rx_level_i == 3'h4 && rxsel_q == 2'h3) // R13
                                |=> irq_stat_q[IRQ_RX])
    else $error("rx full not flagged");
  AST_RX_3Q: assert property ((ce_i && rx_push_i && rx_level_i == 3'h3 && rxsel_q == 2'h2) // R14
                              |=> irq_stat_q[IRQ_RX])
    else $error("rx three quarter not flagged");
  AST_RX_ANY: assert property ((ce_i && rx_push_i && !rxsel_q[1]) |=> irq_stat_q[IRQ_RX]) // R15
    else $error("rx character not flagged");
  AST_UNIMP: assert property ((rd_wait_q && ce_i && raddr_q == ADDR_CTRL) |=> !hrdata_o[12]) // R16
    else $error("bit 12 read as one");
  AST_OVERRUN_ERROR_FLAG: assert property ((ce_i && rx_overrun_i) |=> overrun_error_flag_q) // R17
    else $error("overrun lost");

endmodule

// ==== tb/usc_line_peer.sv ====
`timescale 1ns/1ns
// ****************************************************************
// far-side serial receiver, decodes data and break frames
// ****************************************************************
module usc_line_peer #(
  parameter int BIT = 4
) (
  input  wire logic       clk_i,
  input  wire logic       line_i,
  input  wire logic       oe_i,
  input  wire logic       inv_i,
  input  wire logic       on_i,
  output logic      [7:0] data_o,
  output logic            got_o,
  output logic            brk_o
);
  logic [13:0] bits;
  logic        bad;
  int          n;

  initial begin
    data_o = 8'h00;
    got_o  = 1'b0;
    brk_o  = 1'b0;
    forever begin
      @(posedge clk_i);
      got_o <= 1'b0;
      if (on_i && oe_i && (line_i ^ inv_i) == 1'b0) begin
        bad = 1'b0;
        n   = 0;
        bits = 14'h0;
        repeat (BIT / 2) @(posedge clk_i);
        // sample mid-bit until a stop shows after 8 data bits or 12 zeros
        while (!((n == 9 && bits[9]) || n == 13)) begin
          n = n + 1;
          repeat (BIT) @(posedge clk_i);
          bits[n] = line_i ^ inv_i;
          bad = bad | !oe_i;
        end
        // a frame cut short by a released pin is dropped
        if (!bad && n == 9) begin
          data_o <= bits[8:1];
          brk_o  <= 1'b0;
          got_o  <= 1'b1;
        end else if (!bad && bits[12:1] == 12'h0 && bits[13]) begin
          data_o <= 8'h00;
          brk_o  <= 1'b1;
          got_o  <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top
  import usc_pkg::*;
;
  `define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam int          BITC = 4;
  localparam logic [31:0] TXEN = 32'h0000_0400;
  typedef struct packed {
    logic [31:0] v;
    logic [31:0] m;
  } usc_exp_s;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        tx_pin;
  logic        tx_oe;
  logic        address_detect_enable;
  logic        irq;
  logic        rx_push = 1'b0;
  logic [2:0]  rx_level = 3'h0;
  logic        receiver_idle = 1'b1;
  logic        parity_error_flag = 1'b0;
  logic        framing_error_flag = 1'b0;
  logic        ovr = 1'b0;
  logic        rxda = 1'b0;
  logic        peer_inv = 1'b0;
  logic        peer_on = 1'b1;
  logic [7:0]  peer_data;
  logic        peer_got;
  logic        peer_brk;
  wire logic   line;
  int          checks = 0;
  int          error_cnt = 0;
  usc_exp_s    exp_q[$];
  logic [8:0]  ln_q[$];
  logic        rd_ph = 1'b0;
  logic [7:0]  seed = 8'h37;
  usc_exp_s    ex;
  logic [8:0]  lx;
  logic [1:0]  sel;
  logic        e;
  logic [7:0]  r;

  // pin pulled up while the port does not drive it
  assign line = tx_oe ? tx_pin : 1'b1;

  usc_top #(.BIT_CYCLES_P(BITC), .IR_CYCLES_P(1)) uut (
    .clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .serial_tx_pin_o(tx_pin), .serial_tx_pin_oe_o(tx_oe),
    .address_detect_enable_o(address_detect_enable), .rx_push_i(rx_push), .rx_level_i(rx_level),
    .receiver_idle_i(receiver_idle), .parity_error_i(parity_error_flag), .framing_error_i(framing_error_flag),
    .rx_overrun_i(ovr), .rx_data_available_i(rxda), .irq_o(irq)
  );

  usc_line_peer #(.BIT(BITC)) peer (
    .clk_i(clk), .line_i(line), .oe_i(tx_oe), .inv_i(peer_inv), .on_i(peer_on),
    .data_o(peer_data), .got_o(peer_got), .brk_o(peer_brk)
  );

  always #50 clk = ~clk;

  // ****************************************************************
  // tasks
  // ****************************************************************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    exp_q.push_back({v, m});
    bus(1'b0, a, 32'h0);
  endtask

  task automatic send(input int n);
    repeat (n) begin
      seed = lfsr(seed);
      ln_q.push_back({1'b0, seed});
      wr(ADDR_TXDATA, {24'h0, seed});
    end
  endtask

  task automatic drain;
    while (ln_q.size() != 0) @(posedge clk);
    repeat (3 * BITC) @(posedge clk);
  endtask

  task automatic push(input logic [2:0] l);
    rx_push  <= 1'b1;
    rx_level <= l;
    @(posedge clk);
    rx_push <= 1'b0;
    @(posedge clk);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // result monitor
  // ****************************************************************
  always @(posedge clk) begin
    if (rd_ph && hready === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK(1'b1, 1'b0)
      end else begin
        ex = exp_q.pop_front();
        `CHK(hrdata & ex.m, ex.v & ex.m)
      end
    end
    if (hready === 1'b1) rd_ph = hsel && htrans[1] && !hwrite;
    if (peer_got === 1'b1) begin
      lx = ln_q.size() ? ln_q.pop_front() : 9'h1ff;
      `CHK({peer_brk, peer_data}, lx)
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK({tx_oe, tx_pin, hresp, irq}, 4'h4)
    rd(ADDR_CTRL, 32'h110, 32'hffff_ffff);
    rd(ADDR_IRQ_STAT, 32'h0, 32'hffff_ffff);
    rd(ADDR_IRQ_MASK, 32'h0, 32'hffff_ffff);
    rd(ADDR_CFG, 32'h0, 32'hffff_ffff);
    rd(8'h14, 32'h0, 32'hffff_ffff);
    wr(ADDR_IRQ_MASK, 32'h7);
    // select 11 is never programmed
    for (int s = 0; s < 3; s++) begin
      sel = s[1:0];
      wr(ADDR_IRQ_STAT, 32'h7);
      wr(ADDR_CTRL, TXEN | {sel[1], 1'b0, sel[0], 13'h0});
      @(posedge clk);
      `CHK(tx_oe, 1'b1)
      send(3);
      rd(ADDR_IRQ_STAT, {31'h0, sel != TXSEL_DONE}, 32'h1);
      drain();
      rd(ADDR_IRQ_STAT, 32'h1, 32'h1);
    end
    wr(ADDR_IRQ_STAT, 32'h7);
    wr(ADDR_CTRL, TXEN);
    send(5);
    wr(ADDR_TXDATA, 32'h5a);
    rd(ADDR_CTRL, 32'h200, 32'h300);
    `CHK(irq, 1'b1)
    drain();
    rd(ADDR_CTRL, 32'h100, 32'h300);
    wr(ADDR_IRQ_STAT, 32'h7);
    ln_q.push_back(9'h100);
    wr(ADDR_CTRL, TXEN | 32'h800);
    rd(ADDR_CTRL, 32'hc00, 32'hd00);
    drain();
    rd(ADDR_CTRL, 32'h500, 32'hd00);
    rd(ADDR_IRQ_STAT, 32'h4, 32'h4);
    wr(ADDR_TXDATA, 32'h11);
    wr(ADDR_TXDATA, 32'h22);
    wr(ADDR_TXDATA, 32'h33);
    repeat (6) @(posedge clk);
    wr(ADDR_CTRL, 32'h0);
    @(posedge clk);
    `CHK(tx_oe, 1'b0)
    rd(ADDR_CTRL, 32'h100, 32'h700);
    repeat (60) @(posedge clk);
    wr(ADDR_CTRL, TXEN);
    send(1);
    drain();
    for (int s = 0; s < 4; s++) begin
      for (int l = 1; l < 5; l++) begin
        sel = s[1:0];
        wr(ADDR_CTRL, TXEN | {sel, 6'h0});
        wr(ADDR_IRQ_STAT, 32'h7);
        push(l[2:0]);
        e = !sel[1] || (sel == RXSEL_3Q && l == 3) || (sel == RXSEL_FULL && l == 4);
        rd(ADDR_IRQ_STAT, {30'h0, e, 1'b0}, 32'h2);
        `CHK(irq, e)
      end
    end
    wr(ADDR_IRQ_MASK, 32'h1);
    @(posedge clk);
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_STAT, 32'h2);
    rd(ADDR_IRQ_STAT, 32'h0, 32'h7);
    seed = lfsr(seed);
    r = seed;
    {receiver_idle, parity_error_flag, framing_error_flag, rxda} <= r[3:0];
    ovr <= 1'b1;
    @(posedge clk);
    ovr <= 1'b0;
    @(posedge clk);
    wr(ADDR_CTRL, TXEN | 32'h3f);
    rd(ADDR_CTRL, 32'h522 | {27'h0, r[3:1], 1'b0, r[0]}, 32'hffff_ffff);
    `CHK(address_detect_enable, 1'b1)
    wr(ADDR_CTRL, TXEN);
    rd(ADDR_CTRL, 32'h0, 32'h22);
    peer_on <= 1'b0;
    wr(ADDR_CTRL, TXEN | 32'h4000);
    repeat (3) @(posedge clk);
    `CHK(tx_pin, 1'b0)
    wr(ADDR_CFG, 32'h1);
    repeat (3) @(posedge clk);
    `CHK(tx_pin, 1'b1)
    wr(ADDR_CTRL, TXEN);
    repeat (3) @(posedge clk);
    `CHK(tx_pin, 1'b0)
    stop_test();
  end
endmodule
